/* include/tos_pkg.sv */
// shared constants and types for the trigger and output sequencer
package tos_pkg;
  localparam int CLK_HZ     = 200_000_000;
  localparam int AO_FMIN_HZ = 30_000;
  localparam int AO_FMAX_HZ = 216_000;
  // fastest rate rounds the divisor up, slowest rounds it down
  localparam int AO_DIV_MIN = (CLK_HZ + AO_FMAX_HZ - 1) / AO_FMAX_HZ;
  localparam int AO_DIV_MAX = CLK_HZ / AO_FMIN_HZ;
  localparam int AO_LAT     = 36;
  localparam int AO_DEPTH   = 8192;
  localparam int AI_W       = 24;
  localparam int AO_W       = 32;
  localparam int DIO_N      = 4;
  localparam int DIV_W      = 16;
  localparam int ADDR_W     = 12;

  localparam logic [ADDR_W-1:0] A_CTRL  = 12'h000;
  localparam logic [ADDR_W-1:0] A_STHR  = 12'h004;
  localparam logic [ADDR_W-1:0] A_RTHR  = 12'h008;
  localparam logic [ADDR_W-1:0] A_POST  = 12'h00c;
  localparam logic [ADDR_W-1:0] A_DIV   = 12'h010;
  localparam logic [ADDR_W-1:0] A_CMD   = 12'h014;
  localparam logic [ADDR_W-1:0] A_STAT  = 12'h018;
  localparam logic [ADDR_W-1:0] A_AODAT = 12'h01c;
  localparam logic [ADDR_W-1:0] A_AOSV0 = 12'h020;
  localparam logic [ADDR_W-1:0] A_AOSV1 = 12'h024;
  localparam logic [ADDR_W-1:0] A_AOTOT = 12'h028;
  localparam logic [ADDR_W-1:0] A_DIO   = 12'h02c;

  // status bits, write one to clear
  localparam int ST_DONE_B = 0;
  localparam int ST_URUN_B = 1;

  typedef enum logic [1:0] {
    SYNC_NONE   = 2'h0,
    SYNC_MASTER = 2'h1,
    SYNC_SLAVE  = 2'h2
  } tos_sync_e;

  typedef enum logic [2:0] {
    AIS_SW   = 3'h0,
    AIS_EXTP = 3'h1,
    AIS_EXTN = 3'h2,
    AIS_THRP = 3'h3,
    AIS_THRN = 3'h4
  } tos_ais_e;

  typedef enum logic [1:0] {
    AOS_SW   = 2'h0,
    AOS_EXTP = 2'h1,
    AOS_EXTN = 2'h2
  } tos_aos_e;

  typedef enum logic [1:0] {
    AOM_OFF  = 2'h0,
    AOM_WAVE = 2'h1,
    AOM_CONT = 2'h2
  } tos_aom_e;

  typedef enum logic [1:0] {
    AI_IDLE = 2'h0,
    AI_ARM  = 2'h1,
    AI_PRE  = 2'h2,
    AI_POST = 2'h3
  } tos_ai_e;

  typedef enum logic [1:0] {
    AO_IDLE = 2'h0,
    AO_ARM  = 2'h1,
    AO_LATW = 2'h2,
    AO_RUN  = 2'h3
  } tos_ao_e;

  typedef struct packed {
    logic       ao_two;
    tos_aom_e   ao_mode;
    tos_aos_e   ao_src;
    logic [1:0] ref_ch;
    logic [1:0] st_ch;
    logic       ref_neg;
    logic       ref_sync;
    tos_ais_e   ai_src;
    tos_sync_e  sync;
  } tos_ctrl_s;

  typedef struct packed {
    logic fifo_clr;
    logic ao_stop;
    logic ai_stop;
    logic ao_go;
    logic ai_go;
  } tos_cmd_s;

  localparam int CTRL_W = $bits(tos_ctrl_s);
  localparam int CMD_W  = $bits(tos_cmd_s);
endpackage

/* hdl/tos_edge.sv */
// synchroniser and edge detector for a trigger pin
`timescale 1ns/1ps
module tos_edge
  import tos_pkg::*;
(
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic d,
  output logic      rise,
  output logic      fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic r;
    logic f;
  } tos_edge_s;

  tos_edge_s st;
  tos_edge_s next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.r  = st.s2 & ~st.s3;
    next_st.f  = ~st.s2 & st.s3;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rise = st.r;
  assign fall = st.f;

  a_rise_single: assert property (@(posedge mclk) disable iff (!arst_n)
    rise |=> !rise && !fall) else $error("edge pulse longer than one");
  a_fall_single: assert property (@(posedge mclk) disable iff (!arst_n)
    fall |-> !rise ##1 !fall) else $error("fall pulse repeated");
endmodule

/* hdl/tos_thresh.sv */
// analog threshold crossing detector on a sample stream
`timescale 1ns/1ps
module tos_thresh
  import tos_pkg::*;
#(
  parameter int W = AI_W
)(
  input  wire logic                mclk,
  input  wire logic                arst_n,
  input  wire logic                smp_en,
  input  wire logic signed [W-1:0] smp,
  input  wire logic signed [W-1:0] lvl,
  input  wire logic                neg,
  output logic                     fire
);
  if (W < 2) begin : g_bad_w
    $error("threshold width too small");
  end

  typedef struct packed {
    logic                prim;
    logic signed [W-1:0] prev;
    logic                f;
  } tos_thr_s;

  tos_thr_s st;
  tos_thr_s next_st;

  // fire on a crossing, not a level
  always_comb begin
    next_st   = st;
    next_st.f = 1'b0;
    if (smp_en) begin
      if (neg) begin
        next_st.f = st.prim && !(st.prev < lvl) && (smp < lvl);
      end else begin
        next_st.f = st.prim && !(st.prev > lvl) && (smp > lvl);
      end
      next_st.prev = smp;
      next_st.prim = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign fire = st.f;

  a_fire_cause: assert property (@(posedge mclk) disable iff (!arst_n)
    fire |-> $past(smp_en) && ($past(neg) ? $past(smp) < $past(lvl)
                                          : $past(smp) > $past(lvl)))
    else $error("threshold fired without crossing");
  a_fire_once: assert property (@(posedge mclk) disable iff (!arst_n)
    fire && $stable(lvl) && $stable(neg) |=> !fire)
    else $error("threshold fired twice");
endmodule

/* hdl/tos_top.sv */
// trigger selection, capture phases and output sequencing with apb access
//
// Summary of operation
// - host start command raises the start event when source is software
// - external start fires on the selected rising or falling edge
// - slave mode takes trigger and clock from sync link, not ext pin
// - threshold start fires on upward or downward crossing as set
// - slave mode uses only the sync trigger as start
// - reference threshold crossing ends pre and begins post capture
// - slave may take reference trigger from the sync link
// - output words are 32 bits at unity gain
// - output rate programmable between 30 kHz and 216 kHz
// - first output conversion only after 36 sample clock pulses
// - single value updates at once, no clock, no stop
// - pattern loaded to on-module fifo, emitted at the set rate
// - waveform wraps to first entry and repeats until stopped
// - continuous output runs until all data sent or stopped
// - an empty queue during continuous output flags underrun
// - input and output may start in the same command
// - output starts by command, chosen ext edge, or sync trigger
// - four in and four out lines, outputs zero after reset
// - post capture ends after the programmed sample count
`timescale 1ns/1ps
module tos_top
  import tos_pkg::*;
#(
  parameter int DEPTH   = AO_DEPTH,
  parameter int DIV_MAX = AO_DIV_MAX
)(
  input  wire logic                    mclk,
  input  wire logic                    arst_n,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [ADDR_W-1:0]       paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    ext_trig,
  input  wire logic                    sync_trig_in,
  input  wire logic                    sync_clk_in,
  output logic                         sync_trig_out,
  output logic                         sync_clk_out,
  input  wire logic                    ain_valid,
  input  wire logic signed [AI_W-1:0]  ain0,
  input  wire logic signed [AI_W-1:0]  ain1,
  input  wire logic signed [AI_W-1:0]  ain2,
  output logic                         ai_pre,
  output logic                         ai_post,
  output logic      [AO_W-1:0]         dac0,
  output logic      [AO_W-1:0]         dac1,
  output logic                         dac_stb,
  input  wire logic [DIO_N-1:0]        din,
  output logic      [DIO_N-1:0]        dout
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(AO_LAT + 1);
  localparam logic [LW-1:0] LAT_END = LW'(AO_LAT - 1);
  localparam logic [DIV_W-1:0] DMIN = DIV_W'(AO_DIV_MIN);
  localparam logic [DIV_W-1:0] DMAX = DIV_W'(DIV_MAX);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  // pointers wrap by overflow, so depth must be a power of two
  if (DEPTH < 4 || DEPTH != 2 ** AW || DIV_MAX < AO_DIV_MIN ||
      DIV_MAX >= 2 ** DIV_W) begin : g_bad_par
    $error("unsupported depth or divider limit");
  end

  typedef struct packed {
    tos_ctrl_s                 ctrl;
    logic [AI_W-1:0]           sthr;
    logic [AI_W-1:0]           rthr;
    logic [31:0]               post;
    logic [31:0]               post_n;
    logic [31:0]               tot;
    logic [31:0]               sent;
    logic [DIV_W-1:0]          div;
    logic [DIV_W-1:0]          dcnt;
    logic [DIO_N-1:0]          dout;
    tos_ai_e                   ai;
    tos_ao_e                   ao;
    logic [LW-1:0]             lat;
    logic [AW-1:0]             wp;
    logic [AW-1:0]             rp;
    logic [AW:0]               lvl;
    logic [DEPTH-1:0][AO_W-1:0] mem;
    logic [AO_W-1:0]           dac0;
    logic [AO_W-1:0]           dac1;
    logic                      stb;
    logic                      done;
    logic                      urun;
    logic                      strig;
    logic                      sclk;
    logic [31:0]               prdata;
  } tos_st_s;

  tos_st_s st;
  tos_st_s next_st;

  logic ext_r;
  logic ext_f;
  logic sy_t;
  logic sy_c;
  logic st_fire;
  logic rf_fire;
  logic signed [AI_W-1:0] st_smp;
  logic signed [AI_W-1:0] rf_smp;

  tos_edge u_ext (
    .mclk   (mclk),
    .arst_n (arst_n),
    .d      (ext_trig),
    .rise   (ext_r),
    .fall   (ext_f)
  );

  tos_edge u_stg (
    .mclk   (mclk),
    .arst_n (arst_n),
    .d      (sync_trig_in),
    .rise   (sy_t),
    .fall   ()
  );

  tos_edge u_sck (
    .mclk   (mclk),
    .arst_n (arst_n),
    .d      (sync_clk_in),
    .rise   (sy_c),
    .fall   ()
  );

  always_comb begin
    unique case (st.ctrl.st_ch)
      2'h1:    st_smp = ain1;
      2'h2:    st_smp = ain2;
      default: st_smp = ain0;
    endcase
    unique case (st.ctrl.ref_ch)
      2'h1:    rf_smp = ain1;
      2'h2:    rf_smp = ain2;
      default: rf_smp = ain0;
    endcase
  end

  tos_thresh #(.W(AI_W)) u_sth (
    .mclk   (mclk),
    .arst_n (arst_n),
    .smp_en (ain_valid),
    .smp    (st_smp),
    .lvl    (st.sthr),
    .neg    (st.ctrl.ai_src == AIS_THRN),
    .fire   (st_fire)
  );

  tos_thresh #(.W(AI_W)) u_rth (
    .mclk   (mclk),
    .arst_n (arst_n),
    .smp_en (ain_valid),
    .smp    (rf_smp),
    .lvl    (st.rthr),
    .neg    (st.ctrl.ref_neg),
    .fire   (rf_fire)
  );

  logic slave;
  logic tick;
  logic ai_trig;
  logic ao_trig;
  logic ref_hit;
  logic acc;
  logic mapped;
  logic full;
  logic wr_ok;
  logic emit;
  logic [AW-1:0] step;

  assign slave  = st.ctrl.sync == SYNC_SLAVE;
  // slave paces from the link clock, otherwise from the divider
  assign tick   = slave ? sy_c : (st.dcnt == '0);
  assign acc    = psel && penable;
  assign full   = st.lvl == FULL;
  assign step   = st.ctrl.ao_two ? AW'(2) : AW'(1);
  assign mapped = paddr inside {A_CTRL, A_STHR, A_RTHR, A_POST, A_DIV,
                  A_CMD, A_STAT, A_AODAT, A_AOSV0, A_AOSV1, A_AOTOT,
                  A_DIO};
  assign pready  = acc;
  assign pslverr = acc && (!mapped ||
                   (pwrite && paddr == A_AODAT && full));
  assign wr_ok   = acc && pwrite && !pslverr;
  // first sample only on the last latency pulse
  assign emit = tick && (st.ao == AO_RUN ||
                (st.ao == AO_LATW && st.lat == LAT_END));

  always_comb begin
    ai_trig = 1'b0;
    ao_trig = 1'b0;
    // slave ignores the ext pin entirely
    // only the link trigger starts a slave
    if (slave) begin
      ai_trig = sy_t;
      ao_trig = sy_t;
    end else begin
      unique case (st.ctrl.ai_src)
        AIS_EXTP: ai_trig = ext_r;
        AIS_EXTN: ai_trig = ext_f;
        AIS_THRP: ai_trig = st_fire;
        AIS_THRN: ai_trig = st_fire;
        default:  ai_trig = 1'b0;
      endcase
      unique case (st.ctrl.ao_src)
        AOS_EXTP: ao_trig = ext_r;
        AOS_EXTN: ao_trig = ext_f;
        default:  ao_trig = 1'b0;
      endcase
    end
    // or by the link in slave mode when ref_sync is set
    ref_hit = (slave && st.ctrl.ref_sync) ? sy_t : rf_fire;
  end

  always_comb begin
    tos_cmd_s      c;
    logic [DIV_W-1:0] dv;
    c               = tos_cmd_s'(pwdata[CMD_W-1:0]);
    dv              = pwdata[DIV_W-1:0];
    next_st         = st;
    next_st.stb     = 1'b0;
    next_st.strig   = 1'b0;
    next_st.sclk    = (st.ctrl.sync == SYNC_MASTER) && tick;
    next_st.dcnt    = (st.dcnt == '0) ? st.div - DIV_W'(1)
                                      : st.dcnt - DIV_W'(1);

    unique case (st.ai)
      AI_ARM: begin
        if (ai_trig) begin
          next_st.ai    = AI_PRE;
          next_st.strig = 1'b1;
        end
      end
      AI_PRE: begin
        if (ref_hit) begin
          next_st.ai     = AI_POST;
          next_st.post_n = '0;
        end
      end
      AI_POST: begin
        // stop once the post count is in
        if (ain_valid) begin
          if (st.post_n + 32'h1 >= st.post) begin
            next_st.ai   = AI_IDLE;
            next_st.done = 1'b1;
          end else begin
            next_st.post_n = st.post_n + 32'h1;
          end
        end
      end
      default: ;
    endcase

    unique case (st.ao)
      AO_ARM: begin
        if (ao_trig) begin
          next_st.ao  = AO_LATW;
          next_st.lat = '0;
        end
      end
      AO_LATW: begin
        if (tick && st.lat != LAT_END) begin
          next_st.lat = st.lat + LW'(1);
        end
      end
      default: ;
    endcase

    // one fifo entry per channel per sample pulse
    if (emit) begin
      next_st.ao = AO_RUN;
      if (st.ctrl.ao_mode == AOM_CONT && st.lvl < (AW + 1)'(step)) begin
        next_st.urun = 1'b1;
      end else begin
        next_st.stb  = 1'b1;
        next_st.dac0 = st.mem[st.rp];
        if (st.ctrl.ao_two) begin
          next_st.dac1 = st.mem[st.rp + AW'(1)];
        end
        if (st.ctrl.ao_mode == AOM_CONT) begin
          next_st.rp   = st.rp + step;
          next_st.lvl  = st.lvl - (AW + 1)'(step);
          next_st.sent = st.sent + 32'(step);
          if (st.tot != '0 && st.sent + 32'(step) >= st.tot) begin
            next_st.ao = AO_IDLE;
          end
        end else if ((AW + 1)'(st.rp) + (AW + 1)'(step) >= st.lvl) begin
          next_st.rp = '0;
        end else begin
          next_st.rp = st.rp + step;
        end
      end
    end

    // read data is latched in the setup cycle for a zero-wait access
    if (psel && !penable) begin
      unique case (paddr)
        A_CTRL:  next_st.prdata = 32'(st.ctrl);
        A_STHR:  next_st.prdata = 32'(st.sthr);
        A_RTHR:  next_st.prdata = 32'(st.rthr);
        A_POST:  next_st.prdata = st.post;
        A_DIV:   next_st.prdata = 32'(st.div);
        A_STAT:  next_st.prdata = 32'({st.lvl, st.ao, st.ai,
                                       st.urun, st.done});
        A_AOTOT: next_st.prdata = st.tot;
        A_DIO:   next_st.prdata = 32'({st.dout, din});
        default: next_st.prdata = '0;
      endcase
    end

    if (wr_ok) begin
      unique case (paddr)
        A_CTRL: next_st.ctrl = tos_ctrl_s'(pwdata[CTRL_W-1:0]);
        A_STHR: next_st.sthr = pwdata[AI_W-1:0];
        A_RTHR: next_st.rthr = pwdata[AI_W-1:0];
        A_POST: next_st.post = pwdata;
        A_AOTOT: next_st.tot = pwdata;
        // rate clamped to the legal range
        A_DIV: begin
          next_st.div = (dv < DMIN) ? DMIN : (dv > DMAX) ? DMAX : dv;
        end
        A_DIO: next_st.dout = pwdata[DIO_N-1:0];
        A_AOSV0: begin
          next_st.dac0 = pwdata;
          next_st.stb  = 1'b1;
        end
        A_AOSV1: begin
          next_st.dac1 = pwdata;
          next_st.stb  = 1'b1;
        end
        A_AODAT: begin
          next_st.mem[st.wp] = pwdata;
          next_st.wp         = st.wp + AW'(1);
          next_st.lvl        = next_st.lvl + (AW + 1)'(1);
        end
        // a status bit set in this cycle survives the clear
        A_STAT: begin
          next_st.done = st.done & ~pwdata[ST_DONE_B];
          next_st.urun = st.urun & ~pwdata[ST_URUN_B];
          if (next_st.ai == AI_IDLE && st.ai == AI_POST) begin
            next_st.done = 1'b1;
          end
          if (emit && st.ctrl.ao_mode == AOM_CONT &&
              st.lvl < (AW + 1)'(step)) begin
            next_st.urun = 1'b1;
          end
        end
        A_CMD: begin
          // both go bits act in the same cycle
          // software source starts at the write
          if (c.ai_go && st.ai == AI_IDLE) begin
            next_st.done  = 1'b0;
            next_st.ai    = (!slave && st.ctrl.ai_src == AIS_SW)
                            ? AI_PRE : AI_ARM;
            next_st.strig = !slave && st.ctrl.ai_src == AIS_SW;
          end
          if (c.ao_go && st.ao == AO_IDLE &&
              st.ctrl.ao_mode != AOM_OFF) begin
            next_st.rp   = (st.ctrl.ao_mode == AOM_WAVE) ? '0 : st.rp;
            next_st.sent = '0;
            next_st.lat  = '0;
            next_st.ao   = (!slave && st.ctrl.ao_src == AOS_SW)
                           ? AO_LATW : AO_ARM;
          end
          if (c.ai_stop) begin
            next_st.ai = AI_IDLE;
          end
          if (c.ao_stop) begin
            next_st.ao = AO_IDLE;
          end
          if (c.fifo_clr && st.ao == AO_IDLE) begin
            next_st.wp  = '0;
            next_st.rp  = '0;
            next_st.lvl = '0;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st     <= '0;
      st.div <= DMAX;
    end else begin
      st <= next_st;
    end
  end

  assign prdata        = st.prdata;
  assign sync_trig_out = st.strig && st.ctrl.sync == SYNC_MASTER;
  assign sync_clk_out  = st.sclk;
  assign ai_pre        = st.ai == AI_PRE;
  assign ai_post       = st.ai == AI_POST;
  assign dac0          = st.dac0;
  assign dac1          = st.dac1;
  assign dac_stb       = st.stb;
  assign dout          = st.dout;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_sw_start: assert property (
    wr_ok && paddr == A_CMD && pwdata[0] && !pwdata[2] && !slave
    && st.ai == AI_IDLE && st.ctrl.ai_src == AIS_SW
    |=> st.ai == AI_PRE ##0 st.strig)
    else $error("software start did not begin pre capture");
  a_slave_noext: assert property (
    slave && st.ai == AI_ARM && !sy_t && !wr_ok |=> st.ai == AI_ARM)
    else $error("slave armed start left without link trigger");
  a_lat_count: assert property (
    st.ao == AO_LATW && st.ao != $past(st.ao) |-> st.lat == '0)
    else $error("latency count not cleared on entry");
  a_first_emit: assert property (
    st.ao == AO_RUN && $past(st.ao) == AO_LATW |-> $past(st.lat) == LAT_END)
    else $error("output before latency pulses done");
  a_wave_ptr: assert property (
    st.ao == AO_RUN && st.ctrl.ao_mode == AOM_WAVE && st.lvl != '0
    |-> (AW + 1)'(st.rp) < st.lvl)
    else $error("waveform pointer past pattern end");
  a_underrun: assert property (
    emit && st.ctrl.ao_mode == AOM_CONT && st.lvl == '0 && !wr_ok
    |=> st.urun && !st.stb)
    else $error("empty queue did not flag underrun");
  a_post_end: assert property (
    st.ai == AI_POST && ain_valid && st.post_n + 32'h1 >= st.post
    && !wr_ok |=> st.ai == AI_IDLE && st.done)
    else $error("post capture overran its count");
  a_single_now: assert property (
    wr_ok && paddr == A_AOSV0 |=> dac0 == $past(pwdata) && dac_stb)
    else $error("single value not applied at once");
  a_div_range: assert property (
    st.div >= DMIN && st.div <= DMAX)
    else $error("divider outside rate range");
  a_tick_rate: assert property (
    !slave && tick && st.div == $past(st.div, 2) |=> !tick)
    else $error("divider pulses back to back");
endmodule

/* sim/tos_host.sv */
// host model issuing register reads and writes over apb
`timescale 1ns/1ps
module tos_host
  import tos_pkg::*;
(
  input  wire logic              mclk,
  output logic                   psel    = 1'b0,
  output logic                   penable = 1'b0,
  output logic                   pwrite  = 1'b0,
  output logic      [ADDR_W-1:0] paddr   = '0,
  output logic      [31:0]       pwdata  = '0,
  input  wire logic [31:0]       prdata,
  input  wire logic              pready,
  input  wire logic              pslverr
);
  logic [31:0] rdat;
  logic        err;
  // request held until pready seen at an edge
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
endmodule

/* sim/tos_top_tb.sv */
// self-checking bench for the trigger and output sequencer
`timescale 1ns/1ps
module tos_top_tb
  import tos_pkg::*;
;
  logic mclk = 1'b0, arst_n = 1'b0, ext_trig = 1'b0, ain_valid = 1'b0;
  logic sync_trig_in = 1'b0;
  logic signed [AI_W-1:0] ain0 = '0;
  logic [DIO_N-1:0] din = '0, dout;
  logic psel, penable, pwrite, pready, pslverr, ai_pre, ai_post, dac_stb;
  logic sync_trig_out;
  logic [31:0] dac1;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, dac0, st, x = 32'hcbf08e5a;
  logic [31:0] pat[$], seen[$];
  int stt[$];
  int n_mismatch = 0, cmp_count = 0, t0, i;
  always #2.5 mclk = ~mclk;
  tos_host h(.mclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);
  tos_top #(.DEPTH(16), .DIV_MAX(926)) i_dut(.mclk, .arst_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ext_trig, .sync_trig_in, .sync_clk_in(1'b0), .sync_trig_out,
    .sync_clk_out(), .ain_valid, .ain0, .ain1('0), .ain2('0), .ai_pre,
    .ai_post, .dac0, .dac1, .dac_stb, .din, .dout);
  function automatic logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp);
    cmp_count++;
    if (seen_v !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen_v, exp);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic smp(input int v);
    ain0 <= AI_W'(v);
    ain_valid <= 1'b1;
    @(posedge mclk);
    ain_valid <= 1'b0;
    wt(3);
  endtask
  // stop first: the fifo only clears once output is idle
  task automatic go(input logic [31:0] c, input logic [31:0] cmd);
    h.xfer(1'b1, A_CMD, 32'hc);
    h.xfer(1'b1, A_CMD, 32'h10);
    h.xfer(1'b1, A_CTRL, c);
    foreach (pat[k]) h.xfer(1'b1, A_AODAT, pat[k]);
    h.xfer(1'b1, A_CMD, cmd);
  endtask
  // strobed output words, in order, with their cycle
  always @(posedge mclk) begin
    if (dac_stb === 1'b1) begin
      seen.push_back(dac0);
      stt.push_back(int'($time / 5));
    end
  end
  initial begin
    #500_000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    din <= DIO_N'(rnd());
    wt(10);
    arst_n <= 1'b1;
    chk(32'(dout), 32'h0);
    st = rnd();
    h.xfer(1'b1, A_DIO, st);
    h.xfer(1'b0, A_DIO, '0);
    chk(32'(h.rdat[7:0]), 32'({st[3:0], din}));
    h.xfer(1'b0, 12'h100, '0);
    chk(32'(h.err), 32'h1);
    st = rnd();
    h.xfer(1'b1, A_AOSV0, st);
    wt(1);
    chk(seen[$], st);
    h.xfer(1'b1, A_DIV, 32'h5);
    h.xfer(1'b0, A_DIV, '0);
    chk(h.rdat, 32'(AO_DIV_MIN));
    h.xfer(1'b1, A_POST, 32'h2);
    go(32'h1, 32'h1);
    chk(32'({ai_pre, sync_trig_out}), 32'h3);
    smp(-5);
    smp(5);
    chk(32'({ai_pre, ai_post}), 32'h1);
    smp(6);
    smp(7);
    h.xfer(1'b0, A_STAT, '0);
    chk(32'({ai_post, h.rdat[0]}), 32'h1);
    // threshold on channel 0, which is in the list
    h.xfer(1'b1, A_STHR, 32'd100);
    go(32'hc, 32'h1);
    smp(50);
    chk(32'(ai_pre), 32'h0);
    smp(200);
    chk(32'(ai_pre), 32'h1);
    go(32'h10, 32'h1);
    smp(50);
    chk(32'(ai_pre), 32'h1);
    go(32'h4, 32'h1);
    ext_trig <= 1'b1;
    wt(6);
    chk(32'(ai_pre), 32'h1);
    ext_trig <= 1'b0;
    go(32'h6, 32'h1);
    ext_trig <= 1'b1;
    wt(6);
    chk(32'(ai_pre), 32'h0);
    sync_trig_in <= 1'b1;
    wt(6);
    chk(32'(ai_pre), 32'h1);
    for (i = 0; i < 5; i++) pat.push_back(rnd());
    seen.delete();
    stt.delete();
    go(32'h2000, 32'h2);
    t0 = int'($time / 5);
    for (i = 0; i < 45000 && seen.size() < 7; i++) @(posedge mclk);
    chk(32'((stt[0] - t0) inside {[(AO_LAT-1)*926:AO_LAT*926+3]}), 1);
    for (i = 0; i < 7; i++) begin
      chk(seen[i], pat[i % 5]);
      if (i > 0) chk(32'(stt[i] - stt[i-1]), 32'd926);
    end
    pat.delete();
    // two channels: entries pair up as ch0, ch1
    for (i = 0; i < 2; i++) pat.push_back(rnd());
    go(32'hc000, 32'h3);
    seen.delete();
    chk(32'(ai_pre), 32'h1);
    h.xfer(1'b0, A_STAT, '0);
    chk(32'(h.rdat[5:2]), 32'ha);
    wt(38 * 926);
    chk(32'(seen.size()), 32'h1);
    chk(seen[0], pat[0]);
    chk(dac1, pat[1]);
    h.xfer(1'b0, A_STAT, '0);
    chk(32'(h.rdat[1]), 32'h1);
    stop_test();
  end
endmodule
